// ### design/sccs_top.sv
/*
  sccs_top: system clock source selection, fast divider, glitch-free switch,
  halt gating, slow crystal start-up and pin assignment.
  Assumes all inputs, oscillator levels included, are synchronous to mclk;
  every output is a flip-flop.
*/
// Summary of operation
// - three-bit select picks fast or slow, changeable live
// - one bit picks slow rc or slow crystal
// - one bit picks fast rc or fast crystal
// - select field sets delivered system clock frequency
// - codes 0-6 divide fast by 1-64, 7 slow
// - always one fast and one slow source chosen
// - fast rc gives 4, 8 or 12 MHz
// - two-bit field maps 4, 8, 12, 4 MHz
// - slow crystal 32.768 kHz, slow rc 32 kHz
// - slow crystal enable bit with start-up delay
// - halt gates off system clock, watchdog keeps clock, time base per keep bit
// - pin-share bits give slow crystal pins to oscillator
// - fast rc chosen frees fast crystal pins
// - oscillators also clock watchdog and time base
// - keep bits decide oscillators running during halt, watchdog keeps slow rc
module sccs_top
  import sccs_pkg::*;
#(
  parameter int LXT_START = LXT_START_CYC        // start-up wait, shorten in simulation
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [2:0] sys_clk_select,        // divider / slow select
  input  wire logic       fast_src_select,       // 1: fast crystal, 0: fast rc
  input  wire logic       slow_src_select,       // 1: slow crystal, 0: slow rc
  input  wire logic       fast_osc_halt_keep,    // keep fast oscillator in halt
  input  wire logic       slow_osc_halt_keep,    // keep slow oscillator in halt
  input  wire logic [1:0] fast_rc_freq_select,   // fast rc frequency code
  input  wire logic       slow_crystal_enable,   // start the slow crystal
  input  wire logic       slow_pins_osc_sel,     // pin-share: pins to slow crystal
  input  wire logic       cpu_halt,              // cpu has executed halt
  input  wire logic       wdt_enable,            // watchdog wants slow rc
  input  wire logic       ext_fast_crystal_osc,  // oscillator levels
  input  wire logic       int_fast_rc_osc,
  input  wire logic       ext_slow_crystal_osc,
  input  wire logic       int_slow_rc_osc,
  output logic            sys_clk_r,             // gated system clock
  output logic            fast_clk_r,            // fast path for peripherals
  output logic            sub_clk_r,             // slow path, time base source
  output logic            wdt_clk_r,             // watchdog clock
  output logic            fast_xtal_en_r,        // fast crystal running
  output logic            fast_rc_en_r,          // fast rc running
  output logic            slow_xtal_en_r,        // slow crystal running
  output logic            slow_rc_en_r,          // slow rc running
  output logic            slow_xtal_ready_r,     // start-up wait elapsed
  output logic [3:0]      fast_rc_mhz_r,         // fast rc frequency in MHz
  output logic            fast_pins_io_r,        // fast crystal pins free as i/o
  output logic            slow_pins_osc_r,       // slow crystal pins on oscillator
  output logic            clk_switching_r        // switch-over in progress
);

  // selection now in force, updated only at the safe point
  logic [2:0]   cur_code_r;                     // current select code
  logic         cur_fhs_r;                      // current fast source
  logic         cur_fss_r;                      // current slow source
  sccs_sw_t     sw_state_r;                     // switch-over state
  sccs_sw_t     sw_state_nxt;                   // its next value
  logic         halt_gate_r;                    // system clock gated off
  logic         fast_prev_r;                    // fast level last cycle
  logic [DIV_W-1:0] div_cnt_r;                  // fast edge counter
  logic [LXT_CNT_W-1:0] lxt_cnt_r;              // start-up counter
  logic         use_lxt_r;                      // slow crystal in use, changed at the safe point

  // source muxes: each path always has an oscillator behind it
  wire          fast_lvl  = cur_fhs_r ? ext_fast_crystal_osc : int_fast_rc_osc;
  // an unready crystal would give no clock, so slow rc stands in until ready;
  // the hand-over to the crystal goes through the switch so no system clock pulse is cut
  wire          lxt_want  = slow_src_select & slow_xtal_ready_r;
  wire          slow_lvl  = use_lxt_r ? ext_slow_crystal_osc : int_slow_rc_osc;
  // divider taps: tap 0 is the fast clock itself, tap k is fast / 2^k
  wire [DIV_W:0] div_taps = {div_cnt_r, fast_lvl};
  wire          src_lvl   = (cur_code_r == SEL_SLOW) ? slow_lvl
                                                     : div_taps[cur_code_r];
  // any difference between request and current selection starts a switch
  wire          req_diff  = (sys_clk_select != cur_code_r) |
                            (fast_src_select != cur_fhs_r) |
                            (slow_src_select != cur_fss_r) |
                            (lxt_want != use_lxt_r);
  wire          fast_rise = fast_lvl & ~fast_prev_r;
  wire          halted    = cpu_halt;
  // oscillator run decisions; in halt the keep bits decide
  wire          fast_run  = ~halted | fast_osc_halt_keep;
  wire          slow_run  = ~halted | slow_osc_halt_keep;
  // output follows its source in run, or finishes a high phase while draining
  wire          out_open  = (sw_state_r == SW_RUN) | ((sw_state_r == SW_DRAIN) & sys_clk_r);
  // lxt counter end, cast to the counter width
  wire [LXT_CNT_W-1:0] lxt_end = LXT_CNT_W'(LXT_START - 1);

  // switch-over sequencing
  always_comb begin
    sw_state_nxt = sw_state_r;
    unique case (sw_state_r)
      SW_RUN: begin
        if (req_diff) begin
          sw_state_nxt = SW_DRAIN;
        end
      end
      SW_DRAIN: begin
        // let the current high phase finish so no pulse is cut short
        if (!sys_clk_r) begin
          sw_state_nxt = SW_WAIT;
        end
      end
      SW_WAIT: begin
        // new source must be seen low so its first high is whole
        if (!src_lvl) begin
          sw_state_nxt = SW_RUN;
        end
      end
    endcase
  end

  // state register and selection latch
  always_ff @(posedge mclk) begin
    if (reset) begin
      sw_state_r <= SW_RUN;
      cur_code_r <= SEL_RST;
      cur_fhs_r  <= 1'b0;
      cur_fss_r  <= 1'b0;
      use_lxt_r  <= 1'b0;
    end else begin
      sw_state_r <= sw_state_nxt;
      // take the new selection on leaving drain, while the output is low
      if (sw_state_r == SW_DRAIN && !sys_clk_r) begin
        cur_code_r <= sys_clk_select;
        cur_fhs_r  <= fast_src_select;
        cur_fss_r  <= slow_src_select;
        use_lxt_r  <= lxt_want;
      end
    end
  end

  // fast edge counter feeding the divider taps
  always_ff @(posedge mclk) begin
    if (reset) begin
      fast_prev_r <= 1'b0;
      div_cnt_r   <= '0;
    end else begin
      fast_prev_r <= fast_lvl;
      if (fast_rise) begin
        div_cnt_r <= div_cnt_r + 1'b1;
      end
    end
  end

  // halt gating: only close or open while the output is low
  always_ff @(posedge mclk) begin
    if (reset) begin
      halt_gate_r <= 1'b0;
    end else if (!sys_clk_r) begin
      halt_gate_r <= halted;
    end
  end

  // system clock out, held low during switch-over and halt once the current high phase ends
  always_ff @(posedge mclk) begin
    if (reset) begin
      sys_clk_r <= 1'b0;
    end else begin
      sys_clk_r <= out_open & ~halt_gate_r & ~(halted & ~sys_clk_r)
                   & src_lvl;
    end
  end

  // peripheral, time base and watchdog clocks run apart from the system clock
  always_ff @(posedge mclk) begin
    if (reset) begin
      fast_clk_r <= 1'b0;
      sub_clk_r  <= 1'b0;
      wdt_clk_r  <= 1'b0;
    end else begin
      fast_clk_r <= fast_lvl & fast_run;
      sub_clk_r  <= slow_lvl & slow_run;
      wdt_clk_r  <= int_slow_rc_osc;
    end
  end

  // oscillator enables follow the run decisions
  always_ff @(posedge mclk) begin
    if (reset) begin
      fast_xtal_en_r <= 1'b0;
      fast_rc_en_r   <= 1'b1;
      slow_xtal_en_r <= 1'b0;
      slow_rc_en_r   <= 1'b1;
    end else begin
      fast_xtal_en_r <= fast_run & fast_src_select;
      fast_rc_en_r   <= fast_run & ~fast_src_select;
      slow_xtal_en_r <= slow_run & slow_crystal_enable;
      // the watchdog keeps the slow rc alive whatever the keep bit says
      slow_rc_en_r   <= (slow_run & ~use_lxt_r) | wdt_enable;
    end
  end

  // slow crystal start-up wait; any drop of enable restarts it
  always_ff @(posedge mclk) begin
    if (reset) begin
      lxt_cnt_r         <= '0;
      slow_xtal_ready_r <= 1'b0;
    end else if (!slow_crystal_enable) begin
      lxt_cnt_r         <= '0;
      slow_xtal_ready_r <= 1'b0;
    end else if (!slow_xtal_ready_r) begin
      lxt_cnt_r         <= lxt_cnt_r + 1'b1;
      slow_xtal_ready_r <= (lxt_cnt_r == lxt_end);
    end
  end

  // fast rc frequency decode; unused code falls back to the lowest speed
  wire [3:0] rc_mhz = (fast_rc_freq_select == RC_SEL_8)  ? RC_MHZ_8  :
                      (fast_rc_freq_select == RC_SEL_12) ? RC_MHZ_12 : RC_MHZ_4;

  // pin assignment and status
  always_ff @(posedge mclk) begin
    if (reset) begin
      fast_rc_mhz_r   <= RC_MHZ_4;
      fast_pins_io_r  <= 1'b1;
      slow_pins_osc_r <= 1'b0;
      clk_switching_r <= 1'b0;
    end else begin
      fast_rc_mhz_r   <= rc_mhz;
      fast_pins_io_r  <= ~fast_src_select;
      slow_pins_osc_r <= slow_pins_osc_sel;
      clk_switching_r <= (sw_state_nxt != SW_RUN);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  gate_holds_low_a: assert property (halt_gate_r |=> !sys_clk_r)
    else $error("system clock high while halt gate closed");
  switch_hold_a: assert property ((sw_state_r != SW_RUN) && !sys_clk_r |=> !sys_clk_r)
    else $error("system clock high during switch-over");
  drain_whole_a: assert property ((sw_state_r == SW_DRAIN) && sys_clk_r && src_lvl
      && !halt_gate_r |=> sys_clk_r)
    else $error("system clock high phase cut short at switch-over");
  run_change_a: assert property ((sw_state_r == SW_RUN) && req_diff |=> sw_state_r == SW_DRAIN)
    else $error("select change did not start switch-over");
  rc_freq_map_a: assert property (##1 fast_rc_mhz_r == ($past(fast_rc_freq_select) == RC_SEL_8 ?
      RC_MHZ_8 : $past(fast_rc_freq_select) == RC_SEL_12 ? RC_MHZ_12 : RC_MHZ_4))
    else $error("fast rc frequency wrong");
  fast_pins_a: assert property (##1 fast_pins_io_r == !$past(fast_src_select))
    else $error("fast crystal pins wrongly assigned");
  lxt_not_ready_a: assert property (!slow_crystal_enable |=> !slow_xtal_ready_r)
    else $error("slow crystal ready while disabled");
  fast_halt_stop_a: assert property (cpu_halt && !fast_osc_halt_keep |=> !fast_xtal_en_r && !fast_rc_en_r)
    else $error("fast oscillator runs in halt without keep");
  slow_run_a: assert property (!cpu_halt && slow_crystal_enable |=> slow_xtal_en_r)
    else $error("slow crystal stopped while running");
  slow_follow_a: assert property ((sw_state_r == SW_RUN) && !halt_gate_r && !cpu_halt
      && cur_code_r == SEL_SLOW |=> sys_clk_r == $past(slow_lvl))
    else $error("slow code does not deliver slow clock");
  wdt_clock_a: assert property (##1 wdt_clk_r == $past(int_slow_rc_osc))
    else $error("watchdog clock not from slow rc");

  switch_done_c: cover property (sw_state_r == SW_WAIT ##1 sw_state_r == SW_RUN);
  halt_gate_c:   cover property ($rose(halt_gate_r));
  lxt_ready_c:   cover property ($rose(slow_xtal_ready_r));

endmodule // sccs_top

// ### common/sccs_pkg.sv
/*
  sccs_pkg: constants shared by the system clock source select block.
  Assumes a single 100 MHz core clock; oscillator levels arrive already
  synchronous to that clock.
*/
package sccs_pkg;
  // core clock
  localparam int MCLK_PERIOD_NS    = 10;            // 100 MHz
  // slow crystal start-up wait, in microseconds
  localparam int LXT_START_US      = 1000;
  // start-up wait in core cycles, a least time so it rounds up
  localparam int LXT_START_CYC     = (LXT_START_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int LXT_CNT_W         = 17;            // wide enough for the default wait
  // nominal source frequencies
  localparam int LXT_FREQ_HZ       = 32768;         // slow crystal, fixed
  localparam int INT_SLOW_RC_OSC_FREQ_HZ      = 32000;         // slow rc, nominal
  // select code that picks the slow path; lower codes divide the fast path
  localparam logic [2:0] SEL_SLOW  = 3'h7;
  localparam int DIV_W             = 6;             // taps up to divide by 64
  // fast rc frequency select codes and resulting MHz
  localparam logic [1:0] RC_SEL_4  = 2'h0;
  localparam logic [1:0] RC_SEL_8  = 2'h1;
  localparam logic [1:0] RC_SEL_12 = 2'h2;
  localparam logic [3:0] RC_MHZ_4  = 4'h4;
  localparam logic [3:0] RC_MHZ_8  = 4'h8;
  localparam logic [3:0] RC_MHZ_12 = 4'hc;
  // reset values of control state
  localparam logic [2:0] SEL_RST   = 3'h0;
  // switch-over states, one-hot
  typedef enum logic [2:0] {
    SW_RUN   = 3'h1,   // output follows current source
    SW_DRAIN = 3'h2,   // waiting for output low before letting go
    SW_WAIT  = 3'h4    // waiting for new source low before following
  } sccs_sw_t;
endpackage

// ### sim/tb_top.sv
/*
  tb_top: self-checking bench for the system clock source select block.
  Assumes sccs_pkg and sccs_top are compiled first; oscillator waveforms are
  made here from mclk, each slower than mclk/2.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LXT_START = 8;    // short start-up wait keeps the run brief
  localparam int BOUND     = 3000; // longest wait for any flag, in cycles
  logic       mclk = 1'b0, reset = 1'b1;
  logic [2:0] sys_clk_select = 3'h0;
  logic [1:0] fast_rc_freq_select = 2'h0;
  logic       fast_src_select = 1'b0, slow_src_select = 1'b0, cpu_halt = 1'b0;
  logic       fast_osc_halt_keep = 1'b0, slow_osc_halt_keep = 1'b0, wdt_enable = 1'b0;
  logic       slow_crystal_enable = 1'b0, slow_pins_osc_sel = 1'b0;
  logic       ext_fast_crystal_osc = 1'b0, int_fast_rc_osc = 1'b0;
  logic       ext_slow_crystal_osc = 1'b0, int_slow_rc_osc = 1'b0;
  logic       sys_clk_r, fast_clk_r, sub_clk_r, wdt_clk_r, fast_xtal_en_r, fast_rc_en_r;
  logic       slow_xtal_en_r, slow_rc_en_r, slow_xtal_ready_r, fast_pins_io_r;
  logic       slow_pins_osc_r, clk_switching_r;
  logic [3:0] fast_rc_mhz_r;
  logic [4:0] osc_cnt = 5'h0;                      // source of all oscillator levels
  int         num_errors = 0, n_tests = 0;
  wire  [3:0] clks  = {wdt_clk_r, sub_clk_r, fast_clk_r, sys_clk_r}; // counted outputs
  wire  [1:0] flags = {slow_xtal_ready_r, clk_switching_r};         // awaited flags

  sccs_top #(.LXT_START(LXT_START)) i_sccs_top (.mclk, .reset, .sys_clk_select,
    .fast_src_select, .slow_src_select, .fast_osc_halt_keep, .slow_osc_halt_keep,
    .fast_rc_freq_select, .slow_crystal_enable, .slow_pins_osc_sel, .cpu_halt, .wdt_enable,
    .ext_fast_crystal_osc, .int_fast_rc_osc, .ext_slow_crystal_osc, .int_slow_rc_osc,
    .sys_clk_r, .fast_clk_r, .sub_clk_r, .wdt_clk_r, .fast_xtal_en_r, .fast_rc_en_r,
    .slow_xtal_en_r, .slow_rc_en_r, .slow_xtal_ready_r, .fast_rc_mhz_r, .fast_pins_io_r,
    .slow_pins_osc_r, .clk_switching_r);

  // 100 MHz core clock
  initial forever #5 mclk = ~mclk;

  // periods: fast rc 4, fast crystal 8, slow rc 16, slow crystal 32 cycles
  always @(posedge mclk) begin
    osc_cnt              <= osc_cnt + 5'h1;
    int_fast_rc_osc      <= osc_cnt[1];
    ext_fast_crystal_osc <= osc_cnt[2];
    int_slow_rc_osc      <= osc_cnt[3];
    ext_slow_crystal_osc <= osc_cnt[4];
  end

  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check_bits(input string what, input logic [3:0] exp, input logic [3:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // edge counts depend on phase, so one edge either way is allowed
  task automatic check_count(input string what, input int exp, input int got);
    n_tests++;
    if (got < exp - 1 || got > exp + 1) begin
      num_errors++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // rising edges of one output, looked at on the falling edge once settled
  task automatic count_edges(input int which, input int n, output int c);
    logic prev;
    c = 0;
    prev = clks[which];
    repeat (n) begin
      @(negedge mclk);
      if (clks[which] === 1'b1 && prev !== 1'b1) c++;
      prev = clks[which];
    end
  endtask

  // bounded wait; running out counts a mismatch and ends the run
  task automatic wait_for(input int which, input logic lvl);
    int i;
    for (i = 0; i < BOUND; i++) begin
      @(negedge mclk);
      if (flags[which] === lvl) break;
    end
    if (i == BOUND) begin
      num_errors++;
      $display("unexpected wait on flag %0d: expected %b, seen %b", which, lvl, flags[which]);
      final_report();
    end
  endtask

  // select a code, let the switch finish, then count edges of one output
  task automatic run_count(input logic [2:0] code, input int which, input int n, input int exp);
    int c;
    @(posedge mclk);
    sys_clk_select <= code;
    cycles(3);
    wait_for(0, 1'b0);
    count_edges(which, n, c);
    check_count("edge count", exp, c);
  endtask

  task automatic t_reset();
    @(negedge mclk);
    check_bits("enables", 4'h5, {fast_xtal_en_r, fast_rc_en_r, slow_xtal_en_r, slow_rc_en_r});
    check_bits("pins and ready", 4'h4, {slow_xtal_ready_r, fast_pins_io_r, slow_pins_osc_r, 1'b0});
    check_bits("rc mhz", 4'h4, fast_rc_mhz_r);
  endtask

  task automatic t_rc_freq();
    logic [3:0] table_mhz [4] = '{4'h4, 4'h8, 4'hc, 4'h4};
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      fast_rc_freq_select <= k[1:0];
      cycles(2);
      @(negedge mclk);
      check_bits("rc mhz", table_mhz[k], fast_rc_mhz_r);
    end
  endtask

  // every divide ratio from the fast rc, then the fast crystal undivided
  task automatic t_divider();
    for (int k = 0; k < 7; k++) run_count(k[2:0], 0, 1024, 256 >> k);
    @(posedge mclk);
    fast_src_select <= 1'b1;
    run_count(3'h0, 0, 1024, 128);
    check_bits("fast enables", 4'h2, {2'h0, fast_xtal_en_r, fast_rc_en_r});
    check_bits("fast pins io", 4'h0, {3'h0, fast_pins_io_r});
    @(posedge mclk);
    fast_src_select   <= 1'b0;
    slow_pins_osc_sel <= 1'b1;
    run_count(3'h0, 0, 256, 64);
    check_bits("pin share", 4'h3, {2'h0, fast_pins_io_r, slow_pins_osc_r});
  endtask

  // halt with both keep settings: system clock off, others per keep bit
  task automatic t_halt();
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      cpu_halt           <= 1'b1;
      fast_osc_halt_keep <= k[0];
      slow_osc_halt_keep <= k[0];
      cycles(4);
      run_count(3'h0, 0, 256, 0);
      run_count(3'h0, 1, 256, k * 64);
      run_count(3'h0, 2, 256, k * 16);
    end
    @(posedge mclk);
    cpu_halt <= 1'b0;
    run_count(3'h0, 0, 256, 64);
  endtask

  // crystal chosen before it is ready: slow rc stands in until ready
  task automatic t_slow();
    @(posedge mclk);
    slow_src_select <= 1'b1;
    run_count(3'h7, 0, 512, 32);
    @(posedge mclk);
    slow_crystal_enable <= 1'b1;
    cycles(2);
    @(negedge mclk);
    check_bits("ready early", 4'h0, {3'h0, slow_xtal_ready_r});
    wait_for(1, 1'b1);
    run_count(3'h7, 0, 512, 16);
    check_bits("slow enables", 4'h2, {2'h0, slow_xtal_en_r, slow_rc_en_r});
    @(posedge mclk);
    wdt_enable <= 1'b1;
    run_count(3'h7, 3, 512, 32);
    check_bits("slow rc for wdt", 4'h1, {3'h0, slow_rc_en_r});
    run_count(3'h1, 0, 1024, 128);
  endtask

  initial begin
    cycles(2);
    reset <= 1'b0;
    t_reset();
    t_rc_freq();
    t_divider();
    t_halt();
    t_slow();
    final_report();
  end
endmodule // tb_top
